// ### cag_addr_gen.sv
// Purpose: Program counter update and operand address generation.
// Assumes: Decoder presents one decoded step per cycle on REQ; the table
//   word for a vector call arrives on TABLE_DATA in the step's cycle.
// Notes: All outputs are registered; results appear one cycle after REQ.
// Functional notes
// (RL1) With no branch, PC advances by instruction byte length.
// (RL2) Relative branch adds sign-extended 8-bit offset to next PC.
// (RL3) Short branch and all conditional branches use relative target.
// (RL4) 16-bit absolute call and branch load immediate into PC.
// (RL5) Short region call target always lies in 0800H to 0FFFH.
// (RL6) Vector call reads table entry selected by opcode bits 1..5.
// (RL7) Register-pair branch copies AX into PC.
// (RL8) Unsigned multiply writes A times X into AX.
// (RL9) Divide uses AX implicitly; adjust and nibble rotates use A.
// (RL10) Register chosen from current bank by 3-bit opcode field.
// (RL11) Bytes X..H are 0..7, pairs AX..HL are 0..3.
// (RL12) Direct mode uses 16-bit immediate as operand address.
// (RL13) Short direct confines operand to FE20H..FF1FH by one byte.
// (RL14) Short direct bit 8 is set for bytes 00H..1FH only.
// (RL15) Window holds fast RAM FE20H..FEFFH and SFRs FF00H..FF1FH.
// (RL16) SFR mode covers FF00H..FFCFH and FFE0H..FFFFH from one byte.
// (RL17) Word forms of short direct and SFR need even addresses.
// (RL18) Indirect mode uses DE or HL of selected bank as address.
// (RL19) PC and effective addresses stay 16 bits; carries dropped.
`timescale 1ns/1ns
`default_nettype none
module cag_addr_gen #(
	parameter int BANKS = 4
) (
	input wire logic CLK,
	input wire logic RST,
	input wire cag_pkg::cag_req_t REQ,
	input wire logic BANK_SELECT_LOW_FLAG,
	input wire logic BANK_SELECT_HIGH_FLAG,
	input wire logic [BANKS*64-1:0] REGS,
	input wire logic [15:0] TABLE_DATA,
	output logic [15:0] PC,
	output logic [15:0] TABLE_ADDR,
	output cag_pkg::cag_opnd_t OPND,
	output logic [7:0] REG_VAL,
	output logic [15:0] MUL_PRODUCT,
	output logic MUL_VALID
);
	// -------------------------------------------------------------
	// Register file access
	// -------------------------------------------------------------
	wire logic [1:0] bank;
	wire logic [1:0] opnd_pair;
	wire logic [1:0] ind_pair;
	wire logic [7:0] reg_val;
	wire logic [15:0] pair_val;
	logic [15:0] ax_val;
	logic [7:0] a_val;
	logic [7:0] x_val;

	assign bank = {BANK_SELECT_HIGH_FLAG, BANK_SELECT_LOW_FLAG}; // [RL10]
	assign ind_pair = REQ.pair_hl ? cag_pkg::PAIR_HL : cag_pkg::PAIR_DE;
	assign opnd_pair = (REQ.op_mode == cag_pkg::CAG_OP_INDIR) ?
		ind_pair : cag_pkg::PAIR_AX; // [RL18]

	cag_regbank #(.BANKS(BANKS)) u_rb (
		.regs(REGS),
		.bank(bank),
		.reg_code(REQ.reg_code),
		.pair_code(opnd_pair),
		.reg_val(reg_val),
		.pair_val(pair_val)
	);

	// Accumulator and X are read implicitly from the current bank. [RL9]
	always_comb begin
		a_val = REGS[{bank, cag_pkg::REG_A, 3'b000} +: 8];
		x_val = REGS[{bank, cag_pkg::REG_X, 3'b000} +: 8];
		ax_val = {a_val, x_val}; // [RL11]
	end

	// -------------------------------------------------------------
	// Program counter
	// -------------------------------------------------------------
	// Sum kept at 16 bits so a wrap past FFFFH lands at low memory.
	function automatic logic [15:0] add16(input logic [15:0] a,
		input logic [15:0] b);
		add16 = a + b; // [RL19]
	endfunction

	logic [15:0] pc_r;
	logic [15:0] pc_nxt;
	wire logic [15:0] pc_next_seq;
	wire logic [15:0] rel_ext;
	wire logic [15:0] short_call_tgt;

	assign pc_next_seq = add16(pc_r, {13'h0000, REQ.len}); // [RL1]
	assign rel_ext = {{8{REQ.imm8[cag_pkg::SIGN_BIT]}}, REQ.imm8}; // [RL2]
	// Only the low 11 bits are taken, so the target cannot leave the region.
	assign short_call_tgt = cag_pkg::SHORT_CALL_BASE |
		{5'b0_0000, REQ.imm16[10:0]}; // [RL5]

	// The table index steps by words, so bit 0 of the entry address is 0.
	wire logic [15:0] vec_addr;
	assign vec_addr = cag_pkg::VEC_BASE |
		{10'b00_0000_0000, REQ.imm8[5:1], 1'b0}; // [RL6]

	always_comb begin
		pc_nxt = pc_r;
		if (REQ.valid) begin
			unique case (REQ.pc_src)
				cag_pkg::CAG_PC_SEQ: pc_nxt = pc_next_seq; // [RL1]
				// Short and conditional branches both arrive here. [RL3]
				cag_pkg::CAG_PC_REL: pc_nxt = add16(pc_next_seq, rel_ext); // [RL2]
				cag_pkg::CAG_PC_ABS: pc_nxt = REQ.imm16; // [RL4]
				cag_pkg::CAG_PC_SHORT_CALL: pc_nxt = short_call_tgt; // [RL5]
				cag_pkg::CAG_PC_VEC_CALL: pc_nxt = TABLE_DATA; // [RL6]
				cag_pkg::CAG_PC_REGAX: pc_nxt = ax_val; // [RL7]
				default: pc_nxt = pc_next_seq;
			endcase
		end
	end

	// -------------------------------------------------------------
	// Operand address
	// -------------------------------------------------------------
	wire logic saddr_bit8;
	wire logic [15:0] saddr_ea;
	wire logic [15:0] sfr_ea;
	wire logic sfr_gap;
	logic [15:0] ea;
	logic ea_ok;

	assign saddr_bit8 = (REQ.imm8 < cag_pkg::SADDR_SPLIT); // [RL14]
	// FE00H plus the byte, with bit 8 from the split, spans FE20H..FF1FH.
	assign saddr_ea = cag_pkg::SADDR_BASE |
		{7'b000_0000, saddr_bit8, REQ.imm8}; // [RL13] [RL15]
	assign sfr_ea = cag_pkg::SFR_BASE | {8'h00, REQ.imm8}; // [RL16]
	assign sfr_gap = (sfr_ea >= cag_pkg::SFR_GAP_LO) &&
		(sfr_ea <= cag_pkg::SFR_GAP_HI); // [RL16]

	always_comb begin
		ea = 16'h0000;
		ea_ok = 1'b0;
		unique case (REQ.op_mode)
			cag_pkg::CAG_OP_NONE: begin
				ea = 16'h0000;
				ea_ok = 1'b0;
			end
			cag_pkg::CAG_OP_DIRECT: begin
				ea = REQ.imm16; // [RL12]
				ea_ok = 1'b1;
			end
			cag_pkg::CAG_OP_SADDR: begin
				ea = saddr_ea; // [RL13]
				ea_ok = 1'b1;
			end
			cag_pkg::CAG_OP_SFR: begin
				ea = sfr_ea;
				ea_ok = !sfr_gap; // [RL16]
			end
			cag_pkg::CAG_OP_INDIR: begin
				ea = pair_val; // [RL18]
				ea_ok = 1'b1;
			end
			default: begin
				ea = 16'h0000;
				ea_ok = 1'b0;
			end
		endcase
	end

	// Word access through the one-byte forms must start on an even byte.
	wire logic short_form;
	wire logic odd_word;
	assign short_form = (REQ.op_mode == cag_pkg::CAG_OP_SADDR) ||
		(REQ.op_mode == cag_pkg::CAG_OP_SFR);
	assign odd_word = short_form && REQ.word_op && ea[0]; // [RL17]

	// -------------------------------------------------------------
	// Implied multiply
	// -------------------------------------------------------------
	wire logic [15:0] product;
	assign product = {8'h00, a_val} * {8'h00, x_val}; // [RL8]

	// -------------------------------------------------------------
	// Output registers
	// -------------------------------------------------------------
	cag_pkg::cag_opnd_t opnd_nxt;
	always_comb begin
		opnd_nxt.valid = REQ.valid && ea_ok && !odd_word; // [RL17]
		opnd_nxt.addr = ea;
		opnd_nxt.word_op = REQ.word_op;
		opnd_nxt.misaligned = REQ.valid && odd_word;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pc_r <= cag_pkg::PC_RESET;
			OPND <= '0;
			REG_VAL <= 8'h00;
			MUL_PRODUCT <= 16'h0000;
			MUL_VALID <= 1'b0;
		end else begin
			pc_r <= pc_nxt;
			OPND <= opnd_nxt;
			REG_VAL <= reg_val; // [RL10]
			MUL_PRODUCT <= product; // [RL8]
			MUL_VALID <= REQ.valid && REQ.mul_op;
		end
	end

	// Table address is registered from the step's opcode, so it appears one cycle after the call.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			TABLE_ADDR <= cag_pkg::VEC_BASE;
		end else begin
			TABLE_ADDR <= vec_addr; // [RL6]
		end
	end

	always_comb PC = pc_r;
endmodule
`default_nettype wire

// ### cag_addr_gen_asserts.sv
// Purpose: Port-level checks of the address generator.
// Assumes: Outputs answer one edge after the step is taken.
// Notes: Bound to every cag_addr_gen instance from the testbench.
`timescale 1ns/1ns
`default_nettype none
module cag_addr_gen_asserts #(
	parameter int BANKS = 4
) (
	input wire logic CLK,
	input wire logic RST,
	input wire cag_pkg::cag_req_t REQ,
	input wire logic BANK_SELECT_LOW_FLAG,
	input wire logic BANK_SELECT_HIGH_FLAG,
	input wire logic [BANKS*64-1:0] REGS,
	input wire logic [15:0] TABLE_DATA,
	input wire logic [15:0] PC,
	input wire cag_pkg::cag_opnd_t OPND,
	input wire logic [15:0] MUL_PRODUCT,
	input wire logic MUL_VALID
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	wire logic [1:0] bank = {BANK_SELECT_HIGH_FLAG, BANK_SELECT_LOW_FLAG};
	wire logic [15:0] ax = REGS[bank*64 +:16];
	wire logic [15:0] prod = ax[15:8] * ax[7:0];
	wire logic [15:0] rel_t = PC + REQ.len + {{8{REQ.imm8[7]}}, REQ.imm8};
	wire logic [15:0] sadr = {7'h7F, REQ.imm8 < 8'h20, REQ.imm8};
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence took(int s);
		REQ.valid && REQ.pc_src == s;
	endsequence
	seq_pc_a: assert property (took(0) |=> PC == $past(PC) + $past(REQ.len))
		else $error("sequential pc step wrong");
	rel_pc_a: assert property (took(1) |=> PC == $past(rel_t))
		else $error("relative target wrong");
	abs_pc_a: assert property (took(2) |=> PC == $past(REQ.imm16))
		else $error("absolute target wrong");
	short_call_a: assert property (took(3) |=> PC[15:11] == 5'h01 &&
		PC[10:0] == $past(REQ.imm16[10:0])) else $error("short call wrong");
	table_pc_a: assert property (took(4) |=> PC == $past(TABLE_DATA))
		else $error("table call target wrong");
	pair_pc_a: assert property (took(5) |=> PC == $past(ax))
		else $error("pair branch target wrong");
	pc_hold_a: assert property (!REQ.valid |=> $stable(PC))
		else $error("pc moved without a step");
	mul_out_a: assert property (REQ.valid && REQ.mul_op |=>
		MUL_VALID && MUL_PRODUCT == $past(prod)) else $error("product wrong");
	saddr_ea_a: assert property (REQ.valid && REQ.op_mode == 3'h2 &&
		!REQ.word_op |=> OPND.valid && OPND.addr == $past(sadr))
		else $error("short direct address wrong");
	sfr_gap_a: assert property (REQ.valid && REQ.op_mode == 3'h3 &&
		REQ.imm8[7:4] == 4'hD |=> !OPND.valid) else $error("gap accepted");
endmodule
`default_nettype wire

// ### cag_pkg.sv
// Purpose: Shared constants and carrier types for the address generator.
// Assumes: 16-bit address space, 8-bit data, four register banks.
// Notes: All window bounds and table limits are named here once.
`default_nettype none
package cag_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] SHORT_CALL_BASE = 16'h0800;
	localparam logic [15:0] VEC_BASE = 16'h0040;
	localparam logic [15:0] SADDR_BASE = 16'hFE00;
	localparam logic [15:0] SFR_BASE = 16'hFF00;
	localparam logic [7:0] SADDR_SPLIT = 8'h20;
	localparam logic [15:0] SFR_GAP_LO = 16'hFFD0;
	localparam logic [15:0] SFR_GAP_HI = 16'hFFDF;
	localparam int SADDR_BIT8 = 8;
	localparam int SIGN_BIT = 7;
	localparam logic [2:0] REG_X = 3'h0;
	localparam logic [2:0] REG_A = 3'h1;
	localparam logic [1:0] PAIR_AX = 2'h0;
	localparam logic [1:0] PAIR_DE = 2'h2;
	localparam logic [1:0] PAIR_HL = 2'h3;

	// Program counter source selected by the decoder.
	typedef enum logic [2:0] {
		CAG_PC_SEQ = 3'h0,
		CAG_PC_REL = 3'h1,
		CAG_PC_ABS = 3'h2,
		CAG_PC_SHORT_CALL = 3'h3,
		CAG_PC_VEC_CALL = 3'h4,
		CAG_PC_REGAX = 3'h5
	} cag_pc_src_t;

	// Operand address mode selected by the decoder.
	typedef enum logic [2:0] {
		CAG_OP_NONE = 3'h0,
		CAG_OP_DIRECT = 3'h1,
		CAG_OP_SADDR = 3'h2,
		CAG_OP_SFR = 3'h3,
		CAG_OP_INDIR = 3'h4
	} cag_op_mode_t;

	// One decoded instruction step.
	typedef struct packed {
		logic valid;
		logic [2:0] len;
		cag_pc_src_t pc_src;
		logic [7:0] imm8;
		logic [15:0] imm16;
		cag_op_mode_t op_mode;
		logic word_op;
		logic pair_hl;
		logic [2:0] reg_code;
		logic mul_op;
	} cag_req_t;

	// Operand address produced for the memory bus.
	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic word_op;
		logic misaligned;
	} cag_opnd_t;
endpackage
`default_nettype wire

// ### cag_regbank.sv
// Purpose: Register bank read port for byte and pair operands.
// Assumes: Register file holds 4 banks of 8 bytes, flattened.
// Notes: Pair n is formed from byte registers 2n+1 (high) and 2n (low).
`timescale 1ns/1ns
`default_nettype none
module cag_regbank #(
	parameter int BANKS = 4
) (
	input wire logic [BANKS*64-1:0] regs,
	input wire logic [1:0] bank,
	input wire logic [2:0] reg_code,
	input wire logic [1:0] pair_code,
	output logic [7:0] reg_val,
	output logic [15:0] pair_val
);
	// Registers X,A,C,B,E,D,L,H are numbers 0..7 within a bank.
	function automatic logic [7:0] pick(input logic [BANKS*64-1:0] r,
		input logic [1:0] b, input logic [2:0] n);
		pick = r[{b, n, 3'b000} +: 8];
	endfunction

	assign reg_val = pick(regs, bank, reg_code); // [RL10] [RL11]
	assign pair_val = {pick(regs, bank, {pair_code, 1'b1}),
		pick(regs, bank, {pair_code, 1'b0})}; // [RL11]
endmodule
`default_nettype wire

// ### testbench.sv
// Purpose: Random and corner steps through the address generator.
// Assumes: One step per cycle, answers one edge later.
// Notes: Inputs change on the falling edge only.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	cag_pkg::cag_req_t req;
	cag_pkg::cag_opnd_t opnd;
	logic [255:0] regs;
	logic [15:0] tdata, pc, taddr, mprod, e_pc, e_ta, e_ad, e_mp;
	logic [7:0] rval, e_rv;
	logic clk, rst, bl, bh, mval, e_mv, e_ov, e_mis, e_wo, ck_o, ck_m;
	int err_count, n_checks, i, j;
	logic [7:0] cor [10] = '{8'h80, 8'h7F, 8'h1F, 8'h20, 8'hD0, 8'hDF,
		8'hE0, 8'hFF, 8'h00, 8'hCF};
	cag_addr_gen #(.BANKS(4)) u_dut (.CLK(clk), .RST(rst), .REQ(req),
		.BANK_SELECT_LOW_FLAG(bl), .BANK_SELECT_HIGH_FLAG(bh), .REGS(regs),
		.TABLE_DATA(tdata), .PC(pc), .TABLE_ADDR(taddr), .OPND(opnd),
		.REG_VAL(rval), .MUL_PRODUCT(mprod), .MUL_VALID(mval));
	always #4 clk = ~clk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] pr(input int n);
		return regs[{bh, bl}*64+n*16 +:16];
	endfunction
	task automatic chk(input logic [15:0] a, input logic [15:0] b);
		n_checks++;
		if (a !== b) begin
			err_count++;
			$display("Error %0t got %h want %h", $time, a, b);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		clk = 0; rst = 1; req = '0; regs = '0; tdata = '0; bl = 0; bh = 0;
		e_pc = 16'h0000; ck_o = 0; ck_m = 0;
		void'($urandom(52));
		repeat (3) @(posedge clk);
		@(negedge clk);
		rst = 0;
		for (i = 0; i < 600; i++) begin
			if (i > 0) begin
				chk(pc, e_pc);
				chk(taddr, e_ta);
				chk(16'(rval), 16'(e_rv));
				chk(mprod, e_mp);
				chk(16'(mval), 16'(e_mv));
				chk(16'(opnd.valid), 16'(e_ov));
				if (e_ov) chk(opnd.addr, e_ad);
				chk(16'(opnd.misaligned), 16'(e_mis));
				chk(16'(opnd.word_op), 16'(e_wo));
			end
			// A second reset mid-run checks recovery from a live pipeline.
			if (i == 300) begin
				rst = 1;
				@(negedge clk);
				rst = 0;
				e_pc = 16'h0000;
			end
			req = cag_pkg::cag_req_t'({$urandom, $urandom});
			req.valid = ($urandom % 8) != 0;
			req.len = 3'(1 + $urandom % 4);
			req.pc_src = cag_pkg::cag_pc_src_t'($urandom % 6);
			req.op_mode = cag_pkg::cag_op_mode_t'($urandom % 5);
			for (j = 0; j < 8; j++) regs[j*32 +:32] = $urandom;
			{bh, bl, tdata} = 18'($urandom);
			if (i < 40) begin
				req.valid = 1;
				req.pc_src = cag_pkg::CAG_PC_REL;
				req.imm8 = cor[i%10];
				req.op_mode = i < 20 ? cag_pkg::CAG_OP_SADDR : cag_pkg::CAG_OP_SFR;
				req.word_op = (i % 20) >= 10;
			end
			// The gap refusal is checked on byte forms only.
			if (req.op_mode == 3 && req.imm8[7:4] == 4'hD) req.word_op = 0;
			e_rv = regs[{bh, bl}*64+req.reg_code*8 +:8];
			e_mp = 16'(pr(0) >> 8) * 16'(pr(0) & 16'h00FF);
			e_ta = 16'h0040 | {10'h000, req.imm8[5:1], 1'b0};
			e_mv = req.valid & req.mul_op;
			if (req.valid) case (req.pc_src)
				0: e_pc = e_pc + req.len;
				1: e_pc = e_pc + req.len + {{8{req.imm8[7]}}, req.imm8};
				2: e_pc = req.imm16;
				3: e_pc = {5'h01, req.imm16[10:0]};
				4: e_pc = tdata;
				default: e_pc = pr(0);
			endcase
			ck_o = req.valid && req.op_mode != 0;
			ck_m = ck_o && (req.op_mode == 2 || req.op_mode == 3);
			e_mis = ck_m & req.word_op & req.imm8[0];
			e_wo = req.word_op;
			e_ov = ck_o && !e_mis;
			case (req.op_mode)
				1: e_ad = req.imm16;
				2: e_ad = {7'h7F, req.imm8 < 8'h20, req.imm8};
				3: begin
					e_ad = {8'hFF, req.imm8};
					if (req.imm8[7:4] == 4'hD) e_ov = 0;
				end
				default: e_ad = pr(req.pair_hl ? 3 : 2);
			endcase
			@(negedge clk);
		end
		results();
	end
	initial begin
		#20000;
		err_count++;
		results();
	end
endmodule
bind cag_addr_gen cag_addr_gen_asserts #(.BANKS(BANKS)) u_chk (.CLK(CLK),
	.RST(RST), .REQ(REQ), .BANK_SELECT_LOW_FLAG(BANK_SELECT_LOW_FLAG),
	.BANK_SELECT_HIGH_FLAG(BANK_SELECT_HIGH_FLAG), .REGS(REGS),
	.TABLE_DATA(TABLE_DATA), .PC(PC), .OPND(OPND),
	.MUL_PRODUCT(MUL_PRODUCT), .MUL_VALID(MUL_VALID));
`default_nettype wire
